/* core/odt_pkg.sv */
// Constants shared by both ends of the on-die termination link.
// Assumes one 20 MHz clock on both ends and no software-visible registers.
package odt_pkg;
    // Clock period in picoseconds.
    localparam int CLK_PERIOD_PS = 50000;
    // Latency and hold field widths.
    localparam int AL_W = 5;
    localparam int CWL_W = 4;
    localparam int LAT_W = 6;
    localparam int HOLD_W = 3;
    // Fixed offset in the on/off latency.
    localparam logic [LAT_W-1:0] LAT_OFFSET = 6'h02;
    // Write-to-nominal extra clocks for chopped and full bursts.
    localparam logic [LAT_W-1:0] CHOP_EXTRA = 6'h04;
    localparam logic [LAT_W-1:0] FULL_EXTRA = 6'h06;
    // Depth of the request history line; covers the largest latency.
    localparam int HIST_DEPTH = 32;
    // Controller minimum high times, in clocks.
    localparam logic [HOLD_W-1:0] MIN_HIGH_TIME_SHORT = 3'h4;
    localparam logic [HOLD_W-1:0] MIN_HIGH_TIME_LONG = 3'h6;
    // Asynchronous turn-on and turn-off delays in picoseconds.
    localparam int ASYNC_DELAY_MIN_PS = 2000;
    localparam int ASYNC_DELAY_MAX_PS = 8500;
    localparam int ASYNC_MIN_CYC_RAW = (ASYNC_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ASYNC_MAX_CYC_RAW = ASYNC_DELAY_MAX_PS / CLK_PERIOD_PS;
    // A clock period exceeds the whole window, so one cycle is used.
    localparam int ASYNC_DELAY_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
    // Change skew window in hundredths of a clock; nominal is half.
    localparam int SKEW_MIN_PCT = 30;
    localparam int SKEW_MAX_PCT = 70;
    localparam int SKEW_NOM_PCT = 50;
endpackage

/* core/odt_link_if.sv */
// Link between the memory controller end and the memory device end.
// Assumes both ends share the same clock; the bench joins them.
`timescale 1ns/1ps
interface odt_link_if;
    logic termination_request;
    logic write_cmd;
    logic burst_chop_four;
    logic power_down;
    modport ctrl (
        output termination_request,
        output write_cmd,
        output burst_chop_four,
        output power_down
    );
    modport dram (
        input termination_request,
        input write_cmd,
        input burst_chop_four,
        input power_down
    );
endinterface

/* core/odt_dram_end.sv */
// Termination control of the memory device end.
// Assumes link signals are synchronous to I_MCLK and are sampled on its
// rising edge; the analogue half-clock placement is left to the pad cell.
`timescale 1ns/1ps
module odt_dram_end
    import odt_pkg::*;
(
    // Clock, reset and enable
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    // Link from the controller
    odt_link_if.dram link,
    // Mode settings
    input wire logic [AL_W-1:0] I_ADDITIVE_LATENCY,
    input wire logic [CWL_W-1:0] I_WRITE_COLUMN_LATENCY,
    input wire logic [1:0] I_WRITE_TERM_SELECT,
    input wire logic I_DLL_FROZEN_IN_PD,
    // Termination state
    output logic O_TERM_ON,
    output logic O_TERM_WRITE,
    output logic O_ASYNC_MODE
);

    typedef enum logic [1:0] {
        STR_NOMINAL,
        STR_WAIT_WRITE,
        STR_WRITE
    } strength_type;

    logic [HIST_DEPTH-1:0] hist_r;
    logic [HIST_DEPTH-1:0] hist_nxt;
    logic term_on_r;
    logic term_on_nxt;
    logic term_write_r;
    logic term_write_nxt;
    logic async_r;
    logic async_nxt;
    logic [LAT_W-1:0] since_r;
    logic [LAT_W-1:0] since_nxt;
    logic [LAT_W-1:0] end_r;
    logic [LAT_W-1:0] end_nxt;
    strength_type str_r;
    strength_type str_nxt;

    wire [LAT_W-1:0] term_latency;
    wire [LAT_W-1:0] nom_to_write_latency;
    wire [LAT_W-1:0] write_to_nom_latency_chop;
    wire [LAT_W-1:0] write_to_nom_latency_full;
    wire dynamic_enable;
    wire pd_frozen;
    wire write_seen;
    wire delayed_request;
    wire since_at_cnw;
    wire since_at_end;
    wire [LAT_W-1:0] since_inc;

    // The history line is indexed by latency-1, so the latency must not
    // be zero; legal latency settings always give at least three.
    assign term_latency = LAT_W'(I_ADDITIVE_LATENCY) + LAT_W'(I_WRITE_COLUMN_LATENCY)
        - LAT_OFFSET;
    assign nom_to_write_latency = term_latency;
    assign write_to_nom_latency_chop = CHOP_EXTRA + term_latency;
    assign write_to_nom_latency_full = FULL_EXTRA + term_latency;

    assign dynamic_enable = |I_WRITE_TERM_SELECT;
    assign pd_frozen = link.power_down & I_DLL_FROZEN_IN_PD;

    // Writes count only with dynamic switching on and outside power-down,
    // where the command receivers may be dark.
    assign write_seen = link.write_cmd & dynamic_enable & ~pd_frozen
        & ~link.power_down;

    assign hist_nxt = {hist_r[HIST_DEPTH-2:0], link.termination_request};
    assign delayed_request = hist_r[term_latency[4:0] - 5'h01];

    assign since_inc = (&since_r) ? since_r : since_r + 6'h01;
    assign since_at_cnw = (since_r == nom_to_write_latency);
    assign since_at_end = (since_r == end_r);

    // The request receiver stays live in power-down, so async mode still
    // tracks the pin; one cycle is longer than the whole allowed delay window.
    always_comb begin
        if (async_r) begin
            term_on_nxt = link.termination_request;
        end else begin
            term_on_nxt = delayed_request;
        end
    end

    assign async_nxt = pd_frozen;

    // Strength sequencing; a new write restarts the count so back-to-back
    // writes keep write strength until the last one runs out.
    always_comb begin
        str_nxt = str_r;
        since_nxt = since_inc;
        end_nxt = end_r;
        term_write_nxt = term_write_r;
        if (async_r || !dynamic_enable) begin
            str_nxt = STR_NOMINAL;
            since_nxt = '0;
            term_write_nxt = 1'b0;
        end else if (write_seen) begin
            str_nxt = STR_WAIT_WRITE;
            since_nxt = 6'h01;
            if (link.burst_chop_four) begin
                end_nxt = write_to_nom_latency_chop;
            end else begin
                end_nxt = write_to_nom_latency_full;
            end
        end else begin
            unique case (str_r)
                STR_NOMINAL: begin
                    since_nxt = '0;
                    term_write_nxt = 1'b0;
                end
                STR_WAIT_WRITE: begin
                    if (since_at_cnw) begin
                        str_nxt = STR_WRITE;
                        term_write_nxt = 1'b1;
                    end
                end
                STR_WRITE: begin
                    if (since_at_end) begin
                        str_nxt = STR_NOMINAL;
                        term_write_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    // When a restarting write lands while already at write strength,
    // the strength stays up until the new end count; no glitch to nominal.
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            hist_r <= '0;
            term_on_r <= 1'b0;
            async_r <= 1'b0;
        end else if (I_CE) begin
            hist_r <= hist_nxt;
            term_on_r <= term_on_nxt;
            async_r <= async_nxt;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            str_r <= STR_NOMINAL;
            since_r <= '0;
            end_r <= '0;
            term_write_r <= 1'b0;
        end else if (I_CE) begin
            str_r <= (write_seen && str_r == STR_WRITE) ? STR_WRITE : str_nxt;
            since_r <= since_nxt;
            end_r <= end_nxt;
            term_write_r <= term_write_nxt;
        end
    end

    // The pad cell lands each change half a clock after these edges,
    // inside the skew window given in the package.
    assign O_TERM_ON = term_on_r;
    assign O_TERM_WRITE = term_write_r;
    assign O_ASYNC_MODE = async_r;

endmodule

/* core/odt_ctrl_end.sv */
// Termination request and write command driver of the controller end.
// Assumes the user asks for termination as a level and writes as pulses.
`timescale 1ns/1ps
module odt_ctrl_end
    import odt_pkg::*;
(
    // Clock, reset and enable
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    // User requests
    input wire logic I_TERM_WANT,
    input wire logic I_WRITE_REQ,
    input wire logic I_WRITE_CHOP,
    input wire logic I_POWER_DOWN,
    // Link to the device
    odt_link_if.ctrl link,
    // Status
    output logic O_WRITE_TAKEN,
    output logic O_HOLDING
);

    logic req_r;
    logic wr_r;
    logic chop_r;
    logic pd_r;
    logic taken_r;
    logic holding_r;
    logic [HOLD_W-1:0] hold_r;
    logic [HOLD_W-1:0] hold_nxt;
    logic req_nxt;

    wire write_ok;
    wire rise;
    wire [HOLD_W-1:0] write_hold;
    wire [HOLD_W-1:0] hold_dec;

    assign write_ok = I_WRITE_REQ & ~I_POWER_DOWN & ~pd_r;
    assign req_nxt = I_TERM_WANT | (req_r & (hold_r != '0)) | write_ok;
    assign rise = req_nxt & ~req_r;
    assign write_hold = (I_WRITE_CHOP ? MIN_HIGH_TIME_SHORT : MIN_HIGH_TIME_LONG)
        - 3'h1;
    assign hold_dec = (hold_r == '0) ? hold_r : hold_r - 3'h1;

    // A write raises the request with it, so the hold after the write
    // always applies; the larger of the pending holds wins.
    always_comb begin
        hold_nxt = hold_dec;
        if (rise && (MIN_HIGH_TIME_SHORT - 3'h1) > hold_nxt) begin
            hold_nxt = MIN_HIGH_TIME_SHORT - 3'h1;
        end
        if (write_ok && write_hold > hold_nxt) begin
            hold_nxt = write_hold;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            req_r <= 1'b0;
            wr_r <= 1'b0;
            chop_r <= 1'b0;
            pd_r <= 1'b0;
            taken_r <= 1'b0;
            holding_r <= 1'b0;
            hold_r <= '0;
        end else if (I_CE) begin
            req_r <= req_nxt;
            wr_r <= write_ok;
            chop_r <= write_ok ? I_WRITE_CHOP : chop_r;
            pd_r <= I_POWER_DOWN;
            taken_r <= write_ok;
            holding_r <= req_nxt & (hold_nxt != '0);
            hold_r <= hold_nxt;
        end
    end

    assign link.termination_request = req_r;
    assign link.write_cmd = wr_r;
    assign link.burst_chop_four = chop_r;
    assign link.power_down = pd_r;
    assign O_WRITE_TAKEN = taken_r;
    assign O_HOLDING = holding_r;

endmodule

/* tb/odt_link_properties.sv */
// Assertions on the termination link and the device end's outputs.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
module odt_link_properties
    import odt_pkg::*;
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET,
    // Link
    input wire logic termination_request,
    input wire logic write_cmd,
    input wire logic burst_chop_four,
    input wire logic power_down,
    // Device end
    input wire logic [AL_W-1:0] I_ADDITIVE_LATENCY,
    input wire logic [CWL_W-1:0] I_WRITE_COLUMN_LATENCY,
    input wire logic [1:0] I_WRITE_TERM_SELECT,
    input wire logic I_DLL_FROZEN_IN_PD,
    input wire logic O_TERM_ON,
    input wire logic O_TERM_WRITE,
    input wire logic O_ASYNC_MODE
);
    logic [HIST_DEPTH-1:0] hist_r;
    logic [LAT_W-1:0] cnt_r;
    logic [LAT_W-1:0] ext_r;
    logic exp_r;
    wire logic [LAT_W-1:0] lat = LAT_W'(I_ADDITIVE_LATENCY) + LAT_W'(I_WRITE_COLUMN_LATENCY)
        - LAT_OFFSET;
    wire logic accept = write_cmd && (I_WRITE_TERM_SELECT != 2'h0) && !power_down
        && !O_ASYNC_MODE;
    // The count saturates so an idle link never matches a latency again.
    wire logic [LAT_W-1:0] cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            hist_r <= '0;
            cnt_r <= 6'h3F;
            ext_r <= '0;
            exp_r <= 1'b0;
        end else begin
            hist_r <= {hist_r[HIST_DEPTH-2:0], termination_request};
            cnt_r <= accept ? 6'h00 : cnt_nxt;
            if (accept) ext_r <= burst_chop_four ? CHOP_EXTRA : FULL_EXTRA;
            if (!accept && cnt_nxt == lat) exp_r <= 1'b1;
            else if (!accept && cnt_nxt == lat + ext_r) exp_r <= 1'b0;
        end
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    term_sync_a: assert property (
        !O_ASYNC_MODE && !$past(O_ASYNC_MODE) |-> O_TERM_ON == hist_r[lat])
        else $error("termination off its delayed request");
    term_async_a: assert property (
        O_ASYNC_MODE && $past(O_ASYNC_MODE) |-> O_TERM_ON == hist_r[0])
        else $error("async termination not one edge behind");
    write_strength_a: assert property (O_TERM_WRITE == exp_r)
        else $error("write strength at wrong time");
    async_select_a: assert property (
        O_ASYNC_MODE == $past(power_down && I_DLL_FROZEN_IN_PD))
        else $error("async mode selected wrongly");
    min_high_a: assert property (
        $rose(termination_request) |-> termination_request [*4])
        else $error("request high too briefly");
    chop_hold_a: assert property (
        write_cmd && burst_chop_four |-> termination_request [*4])
        else $error("request dropped after chopped write");
    full_hold_a: assert property (
        write_cmd && !burst_chop_four |-> termination_request [*6])
        else $error("request dropped after full write");
    pd_write_a: assert property (power_down |-> !write_cmd)
        else $error("write issued in power-down");
    cover property (accept && burst_chop_four);
    cover property (accept && !burst_chop_four);
    cover property ($rose(O_ASYNC_MODE));
    cover property ($rose(O_TERM_ON));
endmodule

/* tb/dram_dynamic_termination_ctrl_tb.sv */
// Bench joining the controller end to the device end over the link.
// Assumes a 20 MHz clock; each scenario resets the pair first.
`timescale 1ns/1ps
module dram_dynamic_termination_ctrl_tb;
    import odt_pkg::*;
    logic I_MCLK = 1'b0;
    logic I_RESET = 1'b1;
    logic term_want = 1'b0;
    logic write_req = 1'b0;
    logic write_chop = 1'b0;
    logic pwr_down = 1'b0;
    logic [AL_W-1:0] add_lat = '0;
    logic [CWL_W-1:0] col_lat = 4'h5;
    logic [1:0] sel = 2'h1;
    logic frozen = 1'b0;
    logic term_on, term_write, async_mode, taken, holding;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int first[5];
    int cnt[5];
    odt_link_if link();
    always #25 I_MCLK = ~I_MCLK;
    odt_ctrl_end u_odt_ctrl_end (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_CE(1'b1),
        .I_TERM_WANT(term_want), .I_WRITE_REQ(write_req), .I_WRITE_CHOP(write_chop),
        .I_POWER_DOWN(pwr_down), .link(link.ctrl), .O_WRITE_TAKEN(taken), .O_HOLDING(holding));
    odt_dram_end u_odt_dram_end (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_CE(1'b1),
        .link(link.dram), .I_ADDITIVE_LATENCY(add_lat), .I_WRITE_COLUMN_LATENCY(col_lat),
        .I_WRITE_TERM_SELECT(sel), .I_DLL_FROZEN_IN_PD(frozen), .O_TERM_ON(term_on),
        .O_TERM_WRITE(term_write), .O_ASYNC_MODE(async_mode));
    odt_link_properties u_odt_link_properties (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
        .termination_request(link.termination_request), .write_cmd(link.write_cmd),
        .burst_chop_four(link.burst_chop_four), .power_down(link.power_down),
        .I_ADDITIVE_LATENCY(add_lat), .I_WRITE_COLUMN_LATENCY(col_lat),
        .I_WRITE_TERM_SELECT(sel), .I_DLL_FROZEN_IN_PD(frozen), .O_TERM_ON(term_on),
        .O_TERM_WRITE(term_write), .O_ASYNC_MODE(async_mode));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %0d expected %0d", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic restart(input logic [4:0] al, input logic [1:0] s, input logic fz);
        @(posedge I_MCLK);
        I_RESET <= 1'b1;
        add_lat <= al;
        sel <= s;
        frozen <= fz;
        repeat (16) @(posedge I_MCLK);
        I_RESET <= 1'b0;
    endtask
    // Requests are pulses of one or two cycles; the first edge here withdraws them.
    task automatic watch();
        logic [4:0] s;
        first = '{-1, -1, -1, -1, -1};
        cnt = '{0, 0, 0, 0, 0};
        for (int i = 0; i < 40; i++) begin
            @(posedge I_MCLK);
            term_want <= 1'b0;
            write_req <= 1'b0;
            #1;
            s = {holding, taken, term_write, term_on, link.termination_request};
            for (int k = 0; k < 5; k++) begin
                if (s[k] && first[k] < 0) first[k] = i;
                cnt[k] += s[k];
            end
        end
    endtask
    task automatic sc_sync(input logic [4:0] al);
        restart(al, 2'h1, 1'b0);
        @(posedge I_MCLK);
        term_want <= 1'b1;
        watch();
        check(first[1] - first[0], al + 4);
        check(cnt[1], cnt[0]);
        check(cnt[0] >= 4, 1);
        check(cnt[2], 0);
        check(cnt[4], 3);
    endtask
    task automatic sc_write(input logic [1:0] s, input logic chop, input logic twice);
        restart(5'h00, s, 1'b0);
        @(posedge I_MCLK);
        write_req <= 1'b1;
        write_chop <= chop;
        if (twice) @(posedge I_MCLK);
        watch();
        check(cnt[2], s == 2'h0 ? 0 : (chop ? 4 : 6));
        check(first[2], s == 2'h0 ? -1 : 4);
        check(first[1] - first[0], twice ? 3 : 4);
        check(cnt[0] >= (chop ? 4 : 6), 1);
        check(cnt[3], 1);
    endtask
    task automatic sc_async(input logic fz);
        restart(5'h03, 2'h1, fz);
        @(posedge I_MCLK);
        pwr_down <= 1'b1;
        repeat (3) @(posedge I_MCLK);
        #1;
        check(async_mode, fz);
        @(posedge I_MCLK);
        term_want <= 1'b1;
        write_req <= 1'b1;
        watch();
        check(first[1] - first[0], fz ? 1 : 7);
        check(cnt[1], cnt[0]);
        check(cnt[3] + cnt[2], 0);
        @(posedge I_MCLK);
        pwr_down <= 1'b0;
        repeat (3) @(posedge I_MCLK);
        #1;
        check(async_mode, 0);
    endtask
    initial begin
        sc_sync(5'h00);
        sc_sync(5'h03);
        sc_write(2'h2, 1'b1, 1'b0);
        sc_write(2'h1, 1'b0, 1'b0);
        sc_write(2'h3, 1'b1, 1'b1);
        sc_write(2'h0, 1'b0, 1'b0);
        sc_async(1'b0);
        sc_async(1'b1);
        conclude();
    end
    always @(posedge I_MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end
endmodule
